// File: verilog/csmx_exec.v
// Control store, address map and branch instruction execution unit
`timescale 1ns/10ps
`include "csmx_defs.vh"

module csmx_exec #(
	parameter US_MODULES = 2,
	parameter US_PRESENT = 1
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// Instruction issue
	input  wire        instr_valid,
	input  wire [31:0] instr_word,
	input  wire [31:0] src_reg_val,
	input  wire [31:0] dst_reg_val,
	input  wire [31:0] idx_reg_val,
	input  wire [31:0] final_ea,
	input  wire        legacy_status_word_mode,
	// Status doubleword word 1 from the core
	input  wire [31:0] status_in,
	// Memory answer
	input  wire        mem_rdy,
	input  wire [31:0] mem_rdata,
	// Microcode routine completion
	input  wire        us_done,
	input  wire [3:0]  us_cond,
	// Results
	output reg         busy_r,
	output reg         done_r,
	output reg  [1:0]  trap_r,
	output reg  [31:0] status_out_r,
	output reg         status_we_r,
	output reg         reg_we_r,
	output reg  [2:0]  reg_waddr_r,
	output reg  [31:0] reg_wdata_r,
	output reg  [31:0] chan_addr_r,
	// Main memory port
	output reg         mem_req_r,
	output reg         mem_we_r,
	output reg  [31:0] mem_addr_r,
	output reg  [31:0] mem_wdata_r,
	// Microcode entry
	output reg         us_start_r,
	output reg  [5:0]  us_entry_r
);

	// Idle: decode, and finish the one-cycle instructions here
	localparam ST_IDLE  = 3'h0;
	// Store read: first word out, then second word out
	localparam ST_RD0   = 3'h1;
	localparam ST_RD1   = 3'h2;
	// Store write: first word in, then second word in
	localparam ST_WR0   = 3'h3;
	localparam ST_WR1   = 3'h4;
	// Map load: one memory word per map entry
	localparam ST_MAP   = 3'h5;
	// Waiting on the microcode routine
	localparam ST_JUMP  = 3'h6;
	// Fitted store depth; the address check uses it as well
	localparam US_DEPTH = US_MODULES * `CSMX_US_MOD_WORDS;

	// Store array sized by module count
	reg [63:0] store_mem [0:US_DEPTH-1];
	reg [31:0] map_mem   [0:`CSMX_MAP_ENTRIES-1];

	// Working state of the multi-cycle instructions
	reg [2:0]  state_r;
	// Buffers whichever half of a location waits for its turn
	reg [31:0] hi_word_r;
	reg [11:0] us_addr_r;
	reg [31:0] mem_base_r;
	reg [4:0]  map_idx_r;
	// Status captured at issue; later writes start from it
	reg [31:0] psw_r;

	// Low two bits dropped, so format and byte-select bits on a
	// memory address can never misalign the word pair
	function [31:0] word_addr;
		input [31:0] a;
		begin
			word_addr = {a[31:2], 2'b00};
		end
	endfunction

	// Address above the fitted store or option missing
	function us_bad;
		input [31:0] a;
		begin
			us_bad = (US_PRESENT == 0) || (a > `CSMX_US_MAX_ADDR)
				|| (a >= US_DEPTH);
		end
	endfunction

	// Condition bit one reports a bad access; two to four clear
	function [31:0] set_cc;
		input [31:0] s;
		input        c1;
		begin
			set_cc = s;
			set_cc[`CSMX_CC1_BIT] = c1;
			set_cc[`CSMX_CC2_BIT] = 1'b0;
			set_cc[`CSMX_CC3_BIT] = 1'b0;
			set_cc[`CSMX_CC4_BIT] = 1'b0;
		end
	endfunction

	// Field bit 0 of the instruction layout is word bit 31 here
	wire [15:0] op16   = instr_word[31:16];
	wire [5:0]  op6    = instr_word[31:26];
	wire [3:0]  sub4   = instr_word[19:16];
	wire        priv   = status_in[`CSMX_PRIV_BIT];
	wire [2:0]  rd     = instr_word[25:23];
	wire [2:0]  rs     = instr_word[22:20];
	// Branch word fields, bits 12 and 31 zero
	wire [1:0]  br_x   = instr_word[22:21];
	wire        br_i   = instr_word[20];
	wire [17:0] br_adr = instr_word[18:1];
	wire        br_ok  = ~instr_word[19] & ~instr_word[0];
	wire [2:0]  ch_r   = instr_word[25:23];


	// Pulses default low; one result per instruction
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= ST_IDLE;
			busy_r       <= 1'b0;
			done_r       <= 1'b0;
			trap_r       <= `CSMX_TRAP_NONE;
			status_out_r <= 32'h0000_0000;
			status_we_r  <= 1'b0;
			reg_we_r     <= 1'b0;
			reg_waddr_r  <= 3'h0;
			reg_wdata_r  <= 32'h0000_0000;
			chan_addr_r  <= 32'h0000_0000;
			mem_req_r    <= 1'b0;
			mem_we_r     <= 1'b0;
			mem_addr_r   <= 32'h0000_0000;
			mem_wdata_r  <= 32'h0000_0000;
			us_start_r   <= 1'b0;
			us_entry_r   <= 6'h00;
			hi_word_r    <= 32'h0000_0000;
			us_addr_r    <= 12'h000;
			mem_base_r   <= 32'h0000_0000;
			map_idx_r    <= 5'h00;
			psw_r        <= 32'h0000_0000;
		end else begin
			done_r      <= 1'b0;
			status_we_r <= 1'b0;
			reg_we_r    <= 1'b0;
			us_start_r  <= 1'b0;
			trap_r      <= `CSMX_TRAP_NONE;
			case (state_r)
			ST_IDLE: begin
				if (instr_valid) begin
					psw_r <= status_in;
					if (op16 == `CSMX_OP_SETWIDE) begin
						status_out_r <= status_in
							| (32'h1 << `CSMX_PSD_WIDE_BIT);
						status_we_r  <= 1'b1;
						done_r       <= 1'b1;
					end else if (op16 == `CSMX_OP_CLRWIDE) begin
						status_out_r <= status_in
							& ~(32'h1 << `CSMX_PSD_WIDE_BIT);
						status_we_r  <= 1'b1;
						done_r       <= 1'b1;
					end else if (op16 == `CSMX_OP_USWRITE
						|| op16 == `CSMX_OP_USREAD) begin
						if (!priv) begin
							trap_r <= `CSMX_TRAP_PRIV;
							done_r <= 1'b1;
						end else if (us_bad(op16 == `CSMX_OP_USWRITE
							? dst_reg_val : src_reg_val)) begin
							status_out_r <= set_cc(status_in, 1'b1);
							status_we_r  <= 1'b1;
							trap_r       <= `CSMX_TRAP_UNDEF;
							done_r       <= 1'b1;
						end else if (op16 == `CSMX_OP_USWRITE) begin
							us_addr_r  <= dst_reg_val[11:0];
							mem_base_r <= word_addr(src_reg_val);
							mem_addr_r <= word_addr(src_reg_val);
							mem_we_r   <= 1'b0;
							mem_req_r  <= 1'b1;
							busy_r     <= 1'b1;
							state_r    <= ST_WR0;
						end else begin
							us_addr_r   <= src_reg_val[11:0];
							mem_base_r  <= word_addr(dst_reg_val);
							mem_addr_r  <= word_addr(dst_reg_val);
							mem_wdata_r <= store_mem[src_reg_val[11:0]]
								[63:32];
							hi_word_r   <= store_mem[src_reg_val[11:0]]
								[31:0];
							mem_we_r    <= 1'b1;
							mem_req_r   <= 1'b1;
							busy_r      <= 1'b1;
							state_r     <= ST_RD0;
						end
					end else if (op6 == `CSMX_OP6_LDMAP
						&& (sub4 == `CSMX_SUB_LDMAP
						|| sub4 == `CSMX_SUB_MAPREG)) begin
						if (legacy_status_word_mode) begin
							trap_r <= `CSMX_TRAP_UNDEF;
							done_r <= 1'b1;
						end else if (!priv) begin
							trap_r <= `CSMX_TRAP_PRIV;
							done_r <= 1'b1;
						end else if (sub4 == `CSMX_SUB_MAPREG) begin
							reg_waddr_r <= rd;
							reg_wdata_r <= {
								map_mem[{src_reg_val[4:1], 1'b0}][15:0],
								map_mem[{src_reg_val[4:1], 1'b1}][15:0]};
							reg_we_r    <= 1'b1;
							done_r      <= 1'b1;
						end else begin
							mem_addr_r <= word_addr(dst_reg_val);
							mem_base_r <= word_addr(dst_reg_val);
							mem_we_r   <= 1'b0;
							mem_req_r  <= 1'b1;
							map_idx_r  <= 5'h00;
							busy_r     <= 1'b1;
							state_r    <= ST_MAP;
						end
					end else if (instr_word[31:24] == `CSMX_OP8_USJUMP)
						begin
						if (US_PRESENT == 0) begin
							trap_r <= `CSMX_TRAP_UNDEF;
							done_r <= 1'b1;
						end else begin
							// Low six bits of resolved address
							us_entry_r <= final_ea[`CSMX_US_ENTRY_W-1:0];
							us_start_r <= 1'b1;
							busy_r     <= 1'b1;
							state_r    <= ST_JUMP;
						end
					end else if (op6 == `CSMX_OP6_BRLINK && br_ok) begin
						// Save status with next PC in reg 0
						reg_waddr_r <= 3'h0;
						reg_wdata_r <= status_in;
						reg_we_r    <= 1'b1;
						status_out_r <= status_in;
						status_out_r[`CSMX_PC_MSB:`CSMX_PC_LSB] <=
							(br_x == 2'b00 && !br_i) ? br_adr
							: final_ea[`CSMX_PC_MSB:`CSMX_PC_LSB];
						status_we_r  <= 1'b1;
						done_r       <= 1'b1;
					end else begin
						chan_addr_r <= (ch_r == 3'h0)
							? {16'h0000, instr_word[15:0]}
							: idx_reg_val + {16'h0000, instr_word[15:0]};
						done_r <= 1'b1;
					end
				end
			end

			// The store is written only once both words are in, so
			// a stalled transfer leaves the old location untouched
			ST_WR0: begin
				if (mem_rdy) begin
					hi_word_r  <= mem_rdata;
					mem_addr_r <= mem_base_r + 32'h0000_0004;
					state_r    <= ST_WR1;
				end
			end

			ST_WR1: begin
				if (mem_rdy) begin
					// Second word to the lower half
					store_mem[us_addr_r] <= {hi_word_r, mem_rdata};
					mem_req_r    <= 1'b0;
					// Good op clears all four bits
					status_out_r <= set_cc(psw_r, 1'b0);
					status_we_r  <= 1'b1;
					busy_r       <= 1'b0;
					done_r       <= 1'b1;
					state_r      <= ST_IDLE;
				end
			end

			// Second word is staged while the first is accepted
			ST_RD0: begin
				if (mem_rdy) begin
					mem_addr_r  <= mem_base_r + 32'h0000_0004;
					mem_wdata_r <= hi_word_r;
					state_r     <= ST_RD1;
				end
			end

			ST_RD1: begin
				if (mem_rdy) begin
					mem_req_r    <= 1'b0;
					mem_we_r     <= 1'b0;
					// Good op clears all four bits
					status_out_r <= set_cc(psw_r, 1'b0);
					status_we_r  <= 1'b1;
					busy_r       <= 1'b0;
					done_r       <= 1'b1;
					state_r      <= ST_IDLE;
				end
			end

			// A full map image is taken; partial loads are not offered
			ST_MAP: begin
				if (mem_rdy) begin
					map_mem[map_idx_r] <= mem_rdata;
					if (map_idx_r == 5'h1F) begin
						mem_req_r <= 1'b0;
						busy_r    <= 1'b0;
						done_r    <= 1'b1;
						state_r   <= ST_IDLE;
					end else begin
						map_idx_r  <= map_idx_r + 5'h01;
						mem_addr_r <= mem_addr_r + 32'h0000_0004;
					end
				end
			end

			// The routine owns the condition bits; the rest is kept
			ST_JUMP: begin
				if (us_done) begin
					status_out_r <= {psw_r[31], us_cond, psw_r[26:0]};
					status_we_r  <= 1'b1;
					// PC already points past the jump
					busy_r       <= 1'b0;
					done_r       <= 1'b1;
					state_r      <= ST_IDLE;
				end
			end

			// Unused codes fall back to idle rather than hang
			default: begin
				state_r <= ST_IDLE;
				busy_r  <= 1'b0;
			end
			endcase
		end
	end

endmodule

// File: verilog/csmx_defs.vh
// Constants for the control store and address map instruction unit
`ifndef CSMX_DEFS_VH
`define CSMX_DEFS_VH
// Opcodes of the handled instructions (upper halfword)
`define CSMX_OP_SETWIDE   16'h000D
`define CSMX_OP_CLRWIDE   16'h000F
`define CSMX_OP_USWRITE   16'h000C
`define CSMX_OP_USREAD    16'h000B
// Upper 6 bits of the two-register forms, their 4-bit sub-codes, and the upper 8 bits of the jump
`define CSMX_OP6_LDMAP    6'h0B
`define CSMX_SUB_LDMAP    4'h7
`define CSMX_SUB_MAPREG   4'hA
`define CSMX_OP6_MAPREG   6'h0B
`define CSMX_OP8_USJUMP   8'hFA
`define CSMX_OP6_BRLINK   6'h3E
// Status doubleword word 1 field positions
`define CSMX_PSD_WIDE_BIT 26
`define CSMX_CC1_BIT      30
`define CSMX_CC2_BIT      29
`define CSMX_CC3_BIT      28
`define CSMX_CC4_BIT      27
`define CSMX_PRIV_BIT     31
`define CSMX_PC_LSB       1
`define CSMX_PC_MSB       18
// Control store geometry
`define CSMX_US_MAX_ADDR  32'h0000_0FFF
`define CSMX_US_MOD_WORDS 2048
`define CSMX_US_ENTRY_W   6
// Map geometry
`define CSMX_MAP_ENTRIES  32
`define CSMX_MAP_IMAGE_DESCRIPTOR_LIST_WORDS   16
// Trap codes
`define CSMX_TRAP_NONE    2'h0
`define CSMX_TRAP_UNDEF   2'h1
`define CSMX_TRAP_PRIV    2'h2
`endif

// File: sim/csmx_exec_checker.sv
// Assertion checker for the execution unit ports
`timescale 1ns/10ps
module csmx_exec_checker (
	input logic        sys_clk, rst_n, instr_valid, busy_r, done_r,
	input logic        status_we_r, mem_req_r, mem_rdy, us_start_r, us_done,
	input logic [1:0]  trap_r,
	input logic [3:0]  us_cond,
	input logic [5:0]  us_entry_r,
	input logic [31:0] instr_word, status_in, dst_reg_val, final_ea,
	input logic [31:0] status_out_r, mem_addr_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [3:0]  cond_r;
	logic [15:0] op;
	logic        go;
	assign op = instr_word[31:16];
	assign go = instr_valid && !busy_r;
	// Routine result kept so the later status write can be matched
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			cond_r <= 4'h0;
		else if (us_done)
			cond_r <= us_cond;
	a_set_wide:
	assert property (go && op == 16'h000D |=> status_we_r &&
		status_out_r == ($past(status_in) | 32'h0400_0000))
		else $error("wide bit not set");
	a_clear_wide:
	assert property (go && op == 16'h000F |=> status_we_r &&
		status_out_r == ($past(status_in) & ~32'h0400_0000))
		else $error("wide bit not cleared");
	a_word_align:
	assert property (mem_req_r |-> mem_addr_r[1:0] == 2'h0)
		else $error("memory address not word aligned");
	a_request_hold:
	assert property (mem_req_r && !mem_rdy |=>
		mem_req_r && $stable(mem_addr_r))
		else $error("memory request dropped before ready");
	a_entry_low_bits:
	assert property (us_start_r |-> us_entry_r == final_ea[5:0])
		else $error("wrong microcode entry");
	a_jump_cond:
	assert property (us_done |-> ##[1:3]
		status_we_r && status_out_r[30:27] == cond_r)
		else $error("jump condition bits not from routine");
	a_priv_trap:
	assert property (go && op == 16'h000C && !status_in[31] |-> ##[1:4]
		done_r && trap_r == 2'h2) else $error("no privilege trap");
	a_bad_write:
	assert property (go && op == 16'h000C && status_in[31] &&
		dst_reg_val > 32'h0000_0FFF |-> ##[1:40]
		done_r && trap_r == 2'h1) else $error("no undefined trap");
	c_store: cover property (go && op == 16'h000C);
	c_jump: cover property (us_start_r);
	c_trap: cover property (done_r && trap_r != 2'h0);
endmodule
bind csmx_exec csmx_exec_checker u_csmx_exec_checker (.*);

// File: sim/csmx_mem_model.sv
// Main memory and microcode routine model beside the execution unit
`timescale 1ns/10ps
module csmx_mem_model (
	input  logic        sys_clk, rst_n, mem_req_r, mem_we_r, us_start_r,
	input  logic [31:0] mem_addr_r, mem_wdata_r,
	input  logic [1:0]  lat,
	input  logic [3:0]  cond_set,
	output logic        mem_rdy, us_done,
	output logic [31:0] mem_rdata,
	output logic [3:0]  us_cond
);
	logic [31:0] mem [0:63];
	logic [1:0]  cnt;
	logic [2:0]  run_q;
	int          writes = 0;
	// Off-cycle data inverted so a stale sample cannot pass
	assign mem_rdata = mem_rdy ? mem[mem_addr_r[7:2]] : ~mem[mem_addr_r[7:2]];
	assign us_done = run_q[2];
	assign us_cond = us_done ? cond_set : ~cond_set;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rdy <= 1'b0;
			cnt <= 2'h0;
			run_q <= 3'h0;
		end else begin
			run_q <= {run_q[1:0], us_start_r};
			mem_rdy <= mem_req_r && !mem_rdy && cnt == lat;
			cnt <= (mem_req_r && !mem_rdy && cnt != lat) ? cnt + 2'h1 : 2'h0;
			if (mem_req_r && mem_rdy && mem_we_r) begin
				mem[mem_addr_r[7:2]] <= mem_wdata_r;
				writes++;
			end
		end
	end
endmodule

// File: sim/tb_csmx_exec.sv
// Self-checking bench for the control store and map execution unit
`timescale 1ns/10ps
module tb_csmx_exec;
	logic        sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
	logic        legacy_status_word_mode = 1'b0;
	logic [31:0] instr_word = '0, src_reg_val = '0, dst_reg_val = '0;
	logic [31:0] idx_reg_val = '0, final_ea = '0, status_in = '0;
	logic [1:0]  lat = 2'h0;
	logic [3:0]  cond_set = 4'h0;
	logic        mem_rdy, us_done, busy_r, done_r, status_we_r, reg_we_r;
	logic        mem_req_r, mem_we_r, us_start_r;
	logic [31:0] mem_rdata, status_out_r, reg_wdata_r, chan_addr_r;
	logic [31:0] mem_addr_r, mem_wdata_r, st_v, rd_v;
	logic [3:0]  us_cond, rw_v;
	logic [2:0]  reg_waddr_r;
	logic [1:0]  trap_r, tr_v;
	logic [5:0]  us_entry_r;
	int          errors = 0, cmp_count = 0, w0;
	always #12.5 sys_clk = ~sys_clk;
	csmx_exec u_csmx_exec (.*);
	csmx_mem_model u_csmx_mem_model (.*);
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Issue one instruction and capture the result at done
	task automatic run(logic [31:0] w, st, s, d);
		int n;
		@(posedge sys_clk);
		instr_word <= w;
		status_in <= st;
		src_reg_val <= s;
		dst_reg_val <= d;
		instr_valid <= 1'b1;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		for (n = 0; n < 400 && done_r !== 1'b1; n++)
			@(posedge sys_clk) #1;
		tr_v = trap_r;
		st_v = status_out_r;
		rw_v = {reg_we_r, reg_waddr_r};
		rd_v = reg_wdata_r;
		if (n == 400)
			chk("done", 32'h1, 32'h0);
	endtask
	initial begin
		#500000;
		errors++;
		final_report;
	end
	initial begin
		u_csmx_mem_model.mem[4] = 32'hA5C3_0001;
		u_csmx_mem_model.mem[5] = 32'h3C5A_0002;
		// Map image: entry i holds 1100 plus i in its low half
		for (int i = 0; i < 32; i++)
			u_csmx_mem_model.mem[32 + i] = 32'hFFFF_1100 + i;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		run(32'h000D_0000, 32'h5000_1000, 0, 0);
		chk("trap", 32'h0, {30'h0, tr_v});
		chk("status", 32'h5400_1000, st_v);
		run(32'h000F_0000, 32'h5C00_1000, 0, 0);
		chk("status", 32'h5800_1000, st_v);
		// Top location, memory address carrying stray byte bits
		run(32'h000C_0000, 32'hF800_0000, 32'h13, 32'hFFF);
		chk("trap", 32'h0, {30'h0, tr_v});
		chk("status", 32'h8000_0000, st_v);
		lat <= 2'h2;
		run(32'h000B_0000, 32'hF800_0000, 32'hFFF, 32'h22);
		chk("word 1", 32'hA5C3_0001, u_csmx_mem_model.mem[8]);
		chk("word 2", 32'h3C5A_0002, u_csmx_mem_model.mem[9]);
		w0 = u_csmx_mem_model.writes;
		run(32'h000C_0000, 32'hB800_0000, 32'h10, 32'h1000);
		chk("trap", 32'h1, {30'h0, tr_v});
		chk("status", 32'hC000_0000, st_v);
		run(32'h000B_0000, 32'h8000_0000, 32'h1000, 32'h40);
		chk("trap", 32'h1, {30'h0, tr_v});
		chk("writes", 32'(w0), 32'(u_csmx_mem_model.writes));
		run(32'h000C_0000, 32'h0000_0000, 32'h10, 32'h5);
		chk("trap", 32'h2, {30'h0, tr_v});
		legacy_status_word_mode <= 1'b1;
		run(32'h2C87_0000, 32'h8000_0000, 0, 0);
		chk("trap", 32'h1, {30'h0, tr_v});
		run(32'h2C0A_0000, 32'h8000_0000, 0, 0);
		chk("trap", 32'h1, {30'h0, tr_v});
		legacy_status_word_mode <= 1'b0;
		final_ea <= 32'h0000_12FF;
		cond_set <= 4'hA;
		// Core hands over the resolved address of the chain
		run(32'hFA00_0000, 32'hF800_0000, 0, 0);
		chk("jump cond", 32'hA, {28'h0, st_v[30:27]});
		run(32'hF880_2000, 32'h8000_1000, 0, 0);
		chk("link reg", 32'h8, {28'h0, rw_v});
		chk("link status", 32'h1000, {19'h0, rd_v[31:19]});
		chk("branch pc", 32'h8000_2000, st_v);
		// Privileged and unmapped, image at real address 80
		run(32'h2C87_0000, 32'h8000_0000, 0, 32'h80);
		chk("map trap", 32'h0, {30'h0, tr_v});
		chk("busy", 32'h0, {31'h0, busy_r});
		run(32'h2D8A_0000, 32'h8000_0000, 32'h0B, 0);
		chk("map reg", 32'hB, {28'h0, rw_v});
		chk("map pair", 32'h110A_110B, rd_v);
		idx_reg_val <= 32'h100;
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			instr_word <= i ? 32'hFC00_0010 : 32'hFC80_0010;
			instr_valid <= 1'b1;
			@(posedge sys_clk);
			instr_valid <= 1'b0;
			repeat (2) @(posedge sys_clk);
			#1;
			chk("chan", i ? 32'h10 : 32'h110, chan_addr_r);
		end
		final_report;
	end
endmodule
